// ===== hdl/ibs_idle_timer.sv
/*
  Bus idle timer: counts bus-timing ticks while both lines stay high.
  Assumes synchronised line levels and configuration from the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module ibs_idle_timer (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Lines and configuration
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic [1:0] clk_sel,
  input  wire logic [1:0] bfret,
  // Result
  output logic            bus_free
);

  typedef struct packed {
    logic [1:0] pre_cnt;
    logic [6:0] idle_cnt;
    logic       free;
  } ibs_tmr_s;

  ibs_tmr_s   st;
  ibs_tmr_s   next_st;
  logic [1:0] pre_max;
  logic [6:0] target;

  always_comb begin
    next_st = st;
    pre_max = (clk_sel == ibs_pkg::CLK_SEL_DIV2) ? 2'h1 : ((clk_sel == 2'h1) ? 2'h0 : 2'h3);
    target  = 7'(ibs_pkg::BFRET_BASE_TICKS << bfret);
    if (clk_sel == ibs_pkg::CLK_SEL_NONE || !(scl && sda)) begin
      next_st = '0;
    end else if (st.pre_cnt == pre_max) begin
      next_st.pre_cnt = 2'h0;
      if (st.idle_cnt == 7'(target - 7'h01)) begin
        next_st.free = 1'b1;
      end else begin
        next_st.idle_cnt = 7'(st.idle_cnt + 7'h01);
      end
    end else begin
      next_st.pre_cnt = 2'(st.pre_cnt + 2'h1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign bus_free = st.free;

  a_free_idle_lines : assert property (@(posedge clk) disable iff (!rst_n)
    $rose(bus_free) |-> $past(scl && sda))
    else $error("bus free raised while a line was low");

endmodule // ibs_idle_timer

`default_nettype wire

// ===== hdl/ibs_pkg.sv
/*
  Shared constants for the bus status flag block: register map, field
  positions, reset values, timing counts and the byte tracker states.
  Assumes a 32-bit APB with one register per aligned word.
*/
`default_nettype none

package ibs_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0] ADDR_STATUS   = 8'h00;
  localparam logic [7:0] ADDR_CONFIG   = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;

  localparam logic [2:0] IDX_STATUS   = 3'h0;
  localparam logic [2:0] IDX_CONFIG   = 3'h1;
  localparam logic [2:0] IDX_IRQ_STAT = 3'h2;
  localparam logic [2:0] IDX_IRQ_MASK = 3'h3;
  localparam logic [2:0] IDX_NONE     = 3'h4;

  // ==========================================================================
  // Field positions and reset values
  localparam int STAT_BUS_FREE = 7;
  localparam int STAT_SLAVE    = 6;
  localparam int STAT_MASTER   = 5;
  localparam int STAT_READ     = 4;
  localparam int STAT_DATA     = 3;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  localparam int CFG_CLK_SEL_LSB = 0;
  localparam int CFG_BFRET_LSB   = 4;
  localparam logic [1:0] CLK_SEL_NONE = 2'h0;
  localparam logic [1:0] CLK_SEL_DIV2 = 2'h2;

  localparam int IRQ_BUS_FREE   = 0;
  localparam int IRQ_SLAVE_ON   = 1;
  localparam int IRQ_SLAVE_OFF  = 2;
  localparam int IRQ_MASTER_OFF = 3;

  // ==========================================================================
  // Timing counts
  localparam logic [6:0] BFRET_BASE_TICKS = 7'h08;
  localparam logic [3:0] RISES_PER_BYTE   = 4'h8;
  localparam logic [3:0] RISES_WITH_ACK   = 4'h9;
  localparam logic [4:0] TEN_BIT_HEADER   = 5'h1E;

  // ==========================================================================
  // Byte tracker states
  typedef enum logic [3:0] {
    BYTE_IDLE  = 4'h1,
    BYTE_ADDR1 = 4'h2,
    BYTE_ADDR2 = 4'h4,
    BYTE_DATA  = 4'h8
  } ibs_byte_e;

  // Maps a byte address onto a register index.
  function automatic logic [2:0] ibs_reg_index(input logic [7:0] addr);
    case (addr)
      ADDR_STATUS:   ibs_reg_index = IDX_STATUS;
      ADDR_CONFIG:   ibs_reg_index = IDX_CONFIG;
      ADDR_IRQ_STAT: ibs_reg_index = IDX_IRQ_STAT;
      ADDR_IRQ_MASK: ibs_reg_index = IDX_IRQ_MASK;
      default:       ibs_reg_index = IDX_NONE;
    endcase
  endfunction

endpackage

`default_nettype wire

// ===== hdl/ibs_status.sv
/*
  Status flag logic of a two-wire bus controller with an APB register port:
  bus free, slave active, master active, read request and data flags, plus a
  sticky interrupt status with mask. Assumes the start, restart and stop
  detectors, address matcher and master engine run on pclk and give pulses.
*/
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Bus free after both lines idle timeout.
// - Bus free stays clear without clock select.
// - Slave active on 8th fall after match.
// - Slave active clears on restart, stop, clears.
// - Master active sets when start driven.
// - Master active clears on bus collision.
// - Master active clears after stop shifted out.
// - Timeout clears master only after stop.
// - Read flag shows last matched direction.
// - Read flag changes only on slave match.
// - Data flag tells data from address byte.
module ibs_status (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Bus lines
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  // Controller events
  input  wire logic        module_enable,
  input  wire logic        start_det,
  input  wire logic        restart_det,
  input  wire logic        stop_det,
  input  wire logic        receive_clear_condition_a,
  input  wire logic        receive_clear_condition_b,
  input  wire logic        addr_match,
  input  wire logic        master_start,
  input  wire logic        master_stop_done,
  input  wire logic        bus_collision_flag,
  input  wire logic        bus_timeout_condition,
  // Flags and interrupt
  output logic             bus_free_flag,
  output logic             slave_active_flag,
  output logic             master_active_flag,
  output logic             read_flag,
  output logic             data_flag,
  output logic             irq
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic              scl_q;
    logic [3:0]        rise_cnt;
    logic [7:0]        shreg;
    ibs_pkg::ibs_byte_e byte_state;
    logic              hi_w_match;
    logic              tenbit_armed;
    logic              slave_active;
    logic              master_active;
    logic              read_req;
    logic              data_byte;
    logic              bcl_q;
    logic              timeout_pend;
    logic              free_q;
    logic [1:0]        clk_sel;
    logic [1:0]        bfret;
    logic [3:0]        irq_stat;
    logic [3:0]        irq_mask;
    logic              irq;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
  } ibs_top_s;

  localparam ibs_top_s RESET_ST = '{scl_q: 1'b1, byte_state: ibs_pkg::BYTE_IDLE, default: '0};

  ibs_top_s   st;
  ibs_top_s   next_st;
  logic [1:0] line_s;
  logic       scl_s;
  logic       sda_s;
  logic       bus_free;
  logic       scl_rise;
  logic       scl_fall;
  logic       byte_done;
  logic       match_take;
  logic       slave_ok;
  logic       setup;
  logic       wr_access;
  logic [2:0] idx;
  logic [3:0] irq_ev;
  logic [3:0] irq_clr;

  // ==========================================================================
  // Line synchroniser and idle timer
  ibs_sync #(.W(2)) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     ({scl_in, sda_in}),
    .q     (line_s)
  );

  assign scl_s = line_s[1];
  assign sda_s = line_s[0];

  ibs_idle_timer u_idle (
    .clk      (pclk),
    .rst_n    (presetn),
    .scl      (scl_s),
    .sda      (sda_s),
    .clk_sel  (st.clk_sel),
    .bfret    (st.bfret),
    .bus_free (bus_free)
  );

  // ==========================================================================
  // Next state
  always_comb begin
    next_st    = st;
    scl_rise   = scl_s && !st.scl_q;
    scl_fall   = !scl_s && st.scl_q;
    byte_done  = 1'b0;
    match_take = 1'b0;
    slave_ok   = module_enable && !st.master_active;
    next_st.scl_q  = scl_s;
    next_st.bcl_q  = bus_collision_flag;
    next_st.free_q = bus_free;

    // Bits are taken on rising SCL; a byte ends at the 8th falling edge.
    if (scl_rise) begin
      next_st.shreg = {st.shreg[6:0], sda_s};
      if (st.rise_cnt < ibs_pkg::RISES_WITH_ACK) begin
        next_st.rise_cnt = 4'(st.rise_cnt + 4'h1);
      end
    end
    if (scl_fall) begin
      if (st.rise_cnt == ibs_pkg::RISES_PER_BYTE) begin
        byte_done = 1'b1;
      end else if (st.rise_cnt == ibs_pkg::RISES_WITH_ACK) begin
        next_st.rise_cnt = 4'h0;
      end
    end

    // Slave active clears on bus conditions before any set of this cycle.
    if (restart_det || stop_det || receive_clear_condition_a
        || receive_clear_condition_b) begin
      next_st.slave_active = 1'b0;
    end

    if (byte_done) begin
      case (st.byte_state)
        ibs_pkg::BYTE_ADDR1: begin
          next_st.data_byte = 1'b0;
          next_st.byte_state = ibs_pkg::BYTE_DATA;
          if (st.shreg[7:3] != ibs_pkg::TEN_BIT_HEADER) begin
            match_take = addr_match && slave_ok;
          end else if (!st.shreg[0]) begin
            next_st.hi_w_match = addr_match && slave_ok;
            next_st.byte_state = ibs_pkg::BYTE_ADDR2;
          end else begin
            match_take = addr_match && slave_ok && st.tenbit_armed;
          end
        end
        ibs_pkg::BYTE_ADDR2: begin
          next_st.data_byte  = 1'b0;
          next_st.byte_state = ibs_pkg::BYTE_DATA;
          match_take = addr_match && slave_ok && st.hi_w_match;
          if (match_take) begin
            next_st.tenbit_armed = 1'b1;
          end
        end
        ibs_pkg::BYTE_DATA: begin
          next_st.data_byte = 1'b1;
        end
        ibs_pkg::BYTE_IDLE: begin
          next_st.data_byte = 1'b1;
        end
        default: begin
          next_st.byte_state = ibs_pkg::BYTE_IDLE;
        end
      endcase
    end

    if (match_take) begin
      next_st.slave_active = 1'b1;
      next_st.read_req     = st.shreg[0] && (st.byte_state == ibs_pkg::BYTE_ADDR1);
    end

    if (start_det || restart_det) begin
      next_st.rise_cnt   = 4'h0;
      next_st.byte_state = ibs_pkg::BYTE_ADDR1;
      next_st.hi_w_match = 1'b0;
    end
    if (stop_det) begin
      next_st.byte_state   = ibs_pkg::BYTE_IDLE;
      next_st.tenbit_armed = 1'b0;
    end

    // Master engine tracking; a start of this cycle wins over a collision or stop clear, but not over module disable.
    if (bus_timeout_condition) begin
      next_st.timeout_pend = 1'b1;
    end
    if (bus_collision_flag && !st.bcl_q) begin
      next_st.master_active = 1'b0;
    end
    if (master_stop_done) begin
      next_st.master_active = 1'b0;
      next_st.timeout_pend  = 1'b0;
    end
    if (master_start) begin
      next_st.master_active = 1'b1;
    end
    if (!module_enable) begin
      next_st.master_active = 1'b0;
      next_st.slave_active  = 1'b0;
    end

    // APB slave: one-cycle access phase, read data taken at setup.
    setup     = psel && !penable;
    wr_access = psel && penable && st.pready && pwrite;
    idx       = ibs_pkg::ibs_reg_index(paddr);
    irq_clr   = 4'h0;
    next_st.pready = setup;
    if (setup) begin
      next_st.pslverr = (idx == ibs_pkg::IDX_NONE);
      case (idx)
        ibs_pkg::IDX_STATUS:   next_st.prdata = {24'h000000, bus_free, st.slave_active,
                                                 st.master_active, st.read_req,
                                                 st.data_byte, 3'h0};
        ibs_pkg::IDX_CONFIG:   next_st.prdata = {26'h0, st.bfret, 2'h0, st.clk_sel};
        ibs_pkg::IDX_IRQ_STAT: next_st.prdata = {28'h0000000, st.irq_stat};
        ibs_pkg::IDX_IRQ_MASK: next_st.prdata = {28'h0000000, st.irq_mask};
        default:               next_st.prdata = 32'h00000000;
      endcase
    end else if (st.pready) begin
      next_st.pslverr = 1'b0;
    end
    if (wr_access) begin
      case (idx)
        ibs_pkg::IDX_CONFIG: begin
          next_st.clk_sel = pwdata[ibs_pkg::CFG_CLK_SEL_LSB +: 2];
          next_st.bfret   = pwdata[ibs_pkg::CFG_BFRET_LSB +: 2];
        end
        ibs_pkg::IDX_IRQ_STAT: irq_clr = pwdata[3:0];
        ibs_pkg::IDX_IRQ_MASK: next_st.irq_mask = pwdata[3:0];
        default: begin
          // Status writes and unmapped writes change nothing.
          next_st.irq_mask = st.irq_mask;
        end
      endcase
    end

    // Sticky events: a new event wins over a clear in the same cycle.
    irq_ev = 4'h0;
    irq_ev[ibs_pkg::IRQ_BUS_FREE]   = bus_free && !st.free_q;
    irq_ev[ibs_pkg::IRQ_SLAVE_ON]   = next_st.slave_active && !st.slave_active;
    irq_ev[ibs_pkg::IRQ_SLAVE_OFF]  = !next_st.slave_active && st.slave_active;
    irq_ev[ibs_pkg::IRQ_MASTER_OFF] = !next_st.master_active && st.master_active;
    next_st.irq_stat = (st.irq_stat & ~irq_clr) | irq_ev;
    next_st.irq      = |(next_st.irq_stat & next_st.irq_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= RESET_ST;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // Outputs
  assign prdata             = st.prdata;
  assign pready             = st.pready;
  assign pslverr            = st.pslverr;
  assign bus_free_flag      = bus_free;
  assign slave_active_flag  = st.slave_active;
  assign master_active_flag = st.master_active;
  assign read_flag          = st.read_req;
  assign data_flag          = st.data_byte;
  assign irq                = st.irq;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_free_no_clock : assert property (
    (st.clk_sel == ibs_pkg::CLK_SEL_NONE) [*2] |-> !bus_free_flag)
    else $error("bus free set with no bus-timing clock selected");

  a_slave_match_set : assert property (
    match_take |=> slave_active_flag && !data_flag)
    else $error("slave active not set after a matched address byte");

  a_slave_clear : assert property (
    (restart_det || stop_det) && !match_take |=> !slave_active_flag)
    else $error("slave active survived restart or stop");

  a_master_start : assert property (
    master_start && module_enable |=> master_active_flag)
    else $error("master active not set by a start");

  a_master_collide : assert property (
    $rose(bus_collision_flag) && !master_start |=> !master_active_flag)
    else $error("master active not cleared by a collision");

  a_master_stop : assert property (
    master_stop_done && !master_start |=> !master_active_flag)
    else $error("master active not cleared after stop");

  a_master_timeout : assert property (
    master_active_flag && !master_stop_done && !$rose(bus_collision_flag)
    && module_enable |=> master_active_flag)
    else $error("master active cleared without a stop");

  a_read_hold : assert property (
    !match_take |=> $stable(read_flag))
    else $error("read flag changed without an address match");

  a_data_byte : assert property (
    byte_done && st.byte_state == ibs_pkg::BYTE_DATA |=> data_flag)
    else $error("data flag not set after a data byte");

  a_status_read : assert property (
    setup && ibs_pkg::ibs_reg_index(paddr) == ibs_pkg::IDX_STATUS
    |=> pready && prdata[2:0] == 3'h0 && prdata[31:8] == 24'h000000)
    else $error("status read shows nonzero unimplemented bits");

  a_irq_level : assert property (
    ##1 irq == |($past(next_st.irq_stat) & $past(next_st.irq_mask)))
    else $error("interrupt output does not follow masked status");

  c_slave_read   : cover property (match_take && st.shreg[0]);
  c_ten_bit_low  : cover property (match_take && st.byte_state == ibs_pkg::BYTE_ADDR2);
  c_bus_free     : cover property ($rose(bus_free_flag));
  c_master_cycle : cover property (master_start ##[1:1000] master_stop_done);
  c_timeout_stop : cover property (st.timeout_pend && master_stop_done);

endmodule // ibs_status

`default_nettype wire

// ===== hdl/ibs_sync.sv
/*
  Two-flop synchroniser for the serial bus lines.
  Assumes the inputs are asynchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none

module ibs_sync #(
  parameter int W = 2
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Lines
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } ibs_sync_s;

  ibs_sync_s st;
  ibs_sync_s next_st;

  always_comb begin
    next_st    = st;
    next_st.s1 = d;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // The lines idle high, so no false edge follows reset.
      st <= '1;
    end else begin
      st <= next_st;
    end
  end

  assign q = st.s2;

endmodule // ibs_sync

`default_nettype wire

// ===== sim/ibs_bus_model.sv
/*
  Bus partner model: another master on the two-wire bus driving both lines.
  Assumes pull-ups, so a released line reads high, and paces itself on pclk.
*/
`timescale 1ns/1ps
`default_nettype none

module ibs_bus_model (
  // Clock
  input  wire logic pclk,
  // Bus lines
  output logic      scl,
  output logic      sda
);
  // The link clock stands still high between frames.
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end

  // Half of the 800 ns link period.
  task automatic half();
    repeat (4) @(posedge pclk);
  endtask

  task automatic start_cond();
    sda <= 1'b1;
    half();
    scl <= 1'b1;
    half();
    sda <= 1'b0;
    half();
    scl <= 1'b0;
  endtask

  // Eight bits first bit highest, then a released acknowledge slot.
  task automatic send_byte(input logic [7:0] b);
    for (int i = 0; i < 9; i++) begin
      sda <= (i < 8) ? b[7-i] : 1'b1;
      half();
      scl <= 1'b1;
      half();
      scl <= 1'b0;
    end
  endtask

  task automatic stop_cond();
    sda <= 1'b0;
    half();
    scl <= 1'b1;
    half();
    sda <= 1'b1;
    half();
  endtask
endmodule // ibs_bus_model

`default_nettype wire

// ===== sim/ibs_status_bench.sv
/*
  Self-checking bench for the bus status flag block with a flag model.
  Assumes the partner model on the lines and event pulses on pclk.
*/
`timescale 1ns/1ps
`default_nettype none

module ibs_status_bench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, scl, sda, err;
  logic [7:0]  paddr, b;
  logic [31:0] pwdata, prdata, rd;
  logic [6:0]  ev;
  logic        module_enable, addr_match, bus_collision_flag, bus_timeout_condition;
  logic        bus_free_flag, slave_active_flag, master_active_flag, read_flag, data_flag, irq;
  logic        exp_slave, exp_master, exp_read, exp_data;
  int          num_errors, cmp_count, seed;

  ibs_bus_model ibs_bus_model_i (.pclk(pclk), .scl(scl), .sda(sda));

  ibs_status ibs_status_i (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scl_in(scl), .sda_in(sda), .module_enable(module_enable), .start_det(ev[0]),
    .restart_det(ev[1]), .stop_det(ev[2]), .receive_clear_condition_a(ev[3]),
    .receive_clear_condition_b(ev[4]), .addr_match(addr_match), .master_start(ev[5]),
    .master_stop_done(ev[6]), .bus_collision_flag(bus_collision_flag),
    .bus_timeout_condition(bus_timeout_condition), .bus_free_flag(bus_free_flag),
    .slave_active_flag(slave_active_flag), .master_active_flag(master_active_flag),
    .read_flag(read_flag), .data_flag(data_flag), .irq(irq));

  always #50 pclk = ~pclk;

  // ==========================================================================
  // Compare and drive tasks
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_flags();
    chk_word({28'h0, slave_active_flag, master_active_flag, read_flag, data_flag},
             {28'h0, exp_slave, exp_master, exp_read, exp_data});
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 50) num_errors++;
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic pulse(input int k);
    @(posedge pclk);
    ev[k] <= 1'b1;
    @(posedge pclk);
    ev[k] <= 1'b0;
  endtask

  task automatic settle();
    repeat (8) @(posedge pclk);
  endtask

  // Start or restart (event k), then one address byte with match level m.
  task automatic head(input logic [7:0] a, input logic m, input int k);
    ibs_bus_model_i.start_cond();
    pulse(k);
    addr_match <= m;
    ibs_bus_model_i.send_byte(a);
    addr_match <= 1'b0;
    exp_data = 1'b0;
  endtask

  // Seven-bit address byte; the model keeps the last matched direction.
  task automatic addr_byte(input logic [7:0] a, input logic m);
    head(a, m, 0);
    if (m && !exp_master && module_enable) begin
      exp_slave = 1'b1;
      exp_read  = a[0];
    end
    settle();
  endtask

  task automatic summarize();
    if (num_errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ==========================================================================
  // Watchdog
  initial begin
    #2000000;
    num_errors++;
    summarize();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata, ev} = '0;
    {addr_match, bus_collision_flag, bus_timeout_condition} = '0;
    {exp_slave, exp_master, exp_read, exp_data} = '0;
    module_enable = 1'b1;
    num_errors = 0;
    cmp_count = 0;
    seed = 5266;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, 8'h00, 32'hFFFFFFFF);
    for (int k = 0; k < 5; k++) begin
      apb(1'b0, 8'(k * 4), 32'h0);
      chk_word(rd, 32'h0);
      chk_word({31'h0, err}, {31'h0, k == 4});
    end
    repeat (200) @(posedge pclk);
    chk_word({31'h0, bus_free_flag}, 32'h0);
    apb(1'b1, 8'h04, 32'h01);
    repeat (4) @(posedge pclk);
    chk_word({31'h0, bus_free_flag}, 32'h0);
    repeat (40) @(posedge pclk);
    apb(1'b0, 8'h00, 32'h0);
    chk_word(rd, 32'h80);
    apb(1'b1, 8'h04, 32'h00);
    settle();
    chk_word({31'h0, bus_free_flag}, 32'h0);
    apb(1'b1, 8'h08, 32'h0F);
    apb(1'b1, 8'h0C, 32'h02);
    for (int k = 1; k < 5; k++) begin
      b = {1'b0, 7'($random(seed))};
      addr_byte(b, 1'b1);
      chk_flags();
      if (k == 1) begin
        chk_word({31'h0, irq}, 32'h1);
        apb(1'b0, 8'h08, 32'h0);
        chk_word(rd, 32'h2);
        apb(1'b1, 8'h08, 32'h2);
        settle();
        chk_word({31'h0, irq}, 32'h0);
      end
      ibs_bus_model_i.send_byte(8'($random(seed)));
      exp_data = 1'b1;
      settle();
      chk_flags();
      pulse(k);
      exp_slave = 1'b0;
      settle();
      chk_flags();
      ibs_bus_model_i.stop_cond();
    end
    addr_byte({1'b0, 7'($random(seed))}, 1'b1);
    pulse(2);
    exp_slave = 1'b0;
    addr_byte({1'b0, 6'($random(seed)), ~exp_read}, 1'b0);
    chk_flags();
    // Ten-bit: header write and low byte, restart with header read, then a
    // header read after a stop, which must not count as a match.
    b = {5'h1E, 2'($random(seed)), 1'b0};
    head(b, 1'b1, 0);
    settle();
    chk_flags();
    addr_match <= 1'b1;
    ibs_bus_model_i.send_byte(8'($random(seed)));
    addr_match <= 1'b0;
    exp_slave = 1'b1;
    exp_read  = 1'b0;
    settle();
    chk_flags();
    head(b | 8'h01, 1'b1, 1);
    exp_read = 1'b1;
    settle();
    chk_flags();
    pulse(2);
    exp_slave = 1'b0;
    head(b | 8'h01, 1'b1, 0);
    settle();
    chk_flags();
    ibs_bus_model_i.stop_cond();
    pulse(5);
    exp_master = 1'b1;
    settle();
    chk_flags();
    addr_byte({1'b0, 6'($random(seed)), ~exp_read}, 1'b1);
    chk_flags();
    bus_collision_flag <= 1'b1;
    exp_master = 1'b0;
    settle();
    chk_flags();
    bus_collision_flag <= 1'b0;
    pulse(5);
    bus_timeout_condition <= 1'b1;
    exp_master = 1'b1;
    repeat (20) @(posedge pclk);
    chk_flags();
    pulse(6);
    exp_master = 1'b0;
    settle();
    chk_flags();
    bus_timeout_condition <= 1'b0;
    pulse(5);
    settle();
    module_enable <= 1'b0;
    settle();
    chk_flags();
    summarize();
  end
endmodule // ibs_status_bench

`default_nettype wire
